// file: tws_pkg.sv
// Purpose: Shared constants for the two-wire master transmit sequencer.
// Assumes: 200 MHz system clock, open-drain bus pins resolved outside.
// Notes:   Status codes keep the three low prescaler bits at zero.
package tws_pkg;

    // System clock and bus timing.
    localparam int CLK_MHZ      = 200;
    localparam int HALF_BIT_NS  = 5000;
    localparam int HALF_BIT_CYC = (HALF_BIT_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 16;

    // Data path.
    localparam int DATA_W     = 8;
    localparam int BYTE_BITS  = 8;
    localparam int FIFO_DEPTH = 32;

    // Status codes, upper five bits significant.
    localparam logic [7:0] STATUS_MASK      = 8'hf8;
    localparam logic [7:0] CODE_START       = 8'h08;
    localparam logic [7:0] CODE_REP_START   = 8'h10;
    localparam logic [7:0] CODE_SAW_ACK     = 8'h18;
    localparam logic [7:0] CODE_SAW_NACK    = 8'h20;
    localparam logic [7:0] CODE_DATA_ACKED  = 8'h28;
    localparam logic [7:0] CODE_DATA_NACKED = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST    = 8'h38;
    localparam logic [7:0] CODE_SAR_ACK     = 8'h40;
    localparam logic [7:0] CODE_SAR_NACK    = 8'h48;
    localparam logic [7:0] CODE_NO_INFO     = 8'hf8;

    // Reset values.
    localparam logic [7:0] STATUS_RST = CODE_NO_INFO;

    // Major operating modes.
    typedef enum logic [2:0] {
        mode_none,
        master_transmit_mode,
        master_receive_mode,
        slave_transmit_mode,
        slave_receive_mode
    } tws_mode_t;

endpackage

// file: tws_master_tx.sv
// Purpose: Sequencer for START, address, data bytes and STOP as bus master.
// Assumes: All inputs are synchronous to i_mclk; pins are open drain.
// Notes:   Master receive data phase and slave modes are not built here.
`timescale 1ns/1ps
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             not_full;
    logic             empty;
    logic             push;
    logic             pop;
    // Ready is kept as its own flop so the top's ready output is registered.
    assign push        = i_in_valid && not_full;
    assign pop         = !empty && i_out_ready;
    assign o_in_ready  = not_full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr];
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (push && i_ce) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            not_full <= 1'b1;
            empty    <= 1'b1;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count    <= next_count;
            not_full <= (next_count != (AW + 1)'(DEPTH));
            empty    <= (next_count == '0);
        end
    end
endmodule
// Operation
// - Four major modes exist; master transmit built here, master receive address phase only.
// - Direction bit high reads, low writes.
// - Low data line in slot means acknowledge.
// - High data line in slot means not-acknowledge.
// - Eight data bits then one acknowledge slot.
// - Flag set shows code in upper bits.
// - Transfer held while flag stays set.
// - Master modes entered only through START.
// - Write bit selects transmit, read selects receive.
// - Flag set after byte and acknowledge sampled.
// - Clear with stop request sends STOP.
// - One data byte sent per flag clear.
// - After START flag sets with code 08.
// - Writing one clears flag and continues.
// - Data write with flag low sets collision.
// - Address acknowledge reports 18, 20 or 38.
module tws_master_tx
    import tws_pkg::*;
#(
    parameter int HALF_CYC = HALF_BIT_CYC,
    parameter int DEPTH    = FIFO_DEPTH
) (
    // Clock, reset and freeze
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    // Control register write
    input  wire logic              i_ctl_wr,
    input  wire logic              i_ctl_flag_clr,
    input  wire logic              i_ctl_start,
    input  wire logic              i_ctl_stop,
    input  wire logic              i_ctl_enable,
    // Data register write
    input  wire logic              i_data_wr,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_data_ready,
    // Status
    output logic [7:0]             o_status,
    output logic                   o_flag,
    output logic                   o_write_collision_bit,
    output logic                   o_stop_pending,
    output logic [2:0]             o_mode,
    // Two-wire bus pins
    input  wire logic              i_scl,
    output logic                   o_scl_out,
    output logic                   o_scl_oe,
    input  wire logic              i_sda,
    output logic                   o_sda_out,
    output logic                   o_sda_oe
);
    typedef enum logic [3:0] {
        S_IDLE, S_START_A, S_START_F, S_START_B, S_LOAD, S_BIT_LO,
        S_BIT_HI, S_ACK_LO, S_ACK_HI, S_HOLD, S_STOP_A, S_STOP_B, S_STOP_C
    } tws_state_t;
    tws_state_t        state;
    tws_mode_t         mode;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        bus_status_reg;
    logic [DATA_W-1:0] shreg;
    logic [2:0]        bitn;
    logic              flag;
    logic              write_collision_bit;
    logic              owned;
    logic              is_addr;
    logic              addr_dir;
    logic              stop_pend;
    logic              start_pend;
    logic              scl_oe;
    logic              sda_oe;
    logic              tick;
    logic              ctl_go;
    logic              timed;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [DATA_W-1:0] fifo_data;
    // A write without the enable bit aborts, so a continue must carry it.
    assign ctl_go   = i_ctl_wr && i_ctl_flag_clr && i_ctl_enable;
    assign tick     = (cnt == CNT_W'(HALF_CYC - 1));
    assign timed    = !(state inside {S_IDLE, S_HOLD, S_LOAD});
    assign fifo_pop = (state == S_LOAD) && fifo_valid;
    // Bytes queue here; a write is taken only while the flag is set.
    tws_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_in_valid  (i_data_wr && flag),
        .i_in_data   (i_data),
        .o_in_ready  (o_data_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt <= '0;
        end else if (i_ce) begin
            if (!timed || tick) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            write_collision_bit <= 1'b0;
        end else if (i_ce && i_data_wr) begin
            write_collision_bit <= !flag;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state          <= S_IDLE;
            mode           <= mode_none;
            bus_status_reg <= STATUS_RST;
            shreg          <= '0;
            bitn           <= '0;
            flag           <= 1'b0;
            owned          <= 1'b0;
            is_addr        <= 1'b0;
            addr_dir       <= 1'b0;
            stop_pend      <= 1'b0;
            start_pend     <= 1'b0;
            scl_oe         <= 1'b0;
            sda_oe         <= 1'b0;
        end else if (i_ce) begin
            if (i_ctl_wr && !i_ctl_enable) begin
                // Disabling drops the bus at once, mid byte or not.
                state          <= S_IDLE;
                mode           <= mode_none;
                bus_status_reg <= CODE_NO_INFO;
                flag           <= 1'b0;
                owned          <= 1'b0;
                stop_pend      <= 1'b0;
                start_pend     <= 1'b0;
                scl_oe         <= 1'b0;
                sda_oe         <= 1'b0;
            end else begin
                case (state)
                    S_IDLE, S_HOLD: begin
                        // The clock stays low in hold, stalling the slave.
                        if (ctl_go && (flag || state == S_IDLE)) begin
                            flag           <= 1'b0;
                            bus_status_reg <= CODE_NO_INFO;
                            stop_pend      <= i_ctl_stop && owned;
                            start_pend     <= i_ctl_start;
                            if (i_ctl_stop && owned) begin
                                state <= S_STOP_A;
                            end else if (i_ctl_start) begin
                                state <= S_START_A;
                            end else if (owned && mode != master_receive_mode
                                         && bus_status_reg != CODE_NO_INFO) begin
                                state <= S_LOAD;
                            end
                        end
                    end
                    S_START_A: begin
                        sda_oe <= 1'b0;
                        if (tick) begin
                            scl_oe <= 1'b0;
                            state  <= S_START_F;
                        end
                    end
                    S_START_F: begin
                        // Wait for a free bus: both lines released high.
                        if (tick && i_sda && i_scl) begin
                            sda_oe <= 1'b1;
                            state  <= S_START_B;
                        end
                    end
                    S_START_B: begin
                        if (tick) begin
                            scl_oe         <= 1'b1;
                            flag           <= 1'b1;
                            bus_status_reg <= owned ? CODE_REP_START
                                                    : CODE_START;
                            owned          <= 1'b1;
                            is_addr        <= 1'b1;
                            start_pend     <= 1'b0;
                            state          <= S_HOLD;
                        end
                    end
                    S_LOAD: begin
                        if (fifo_valid) begin
                            shreg  <= fifo_data;
                            bitn   <= '0;
                            sda_oe <= !fifo_data[7];
                            if (is_addr) begin
                                addr_dir <= fifo_data[0];
                            end
                            state <= S_BIT_LO;
                        end
                    end
                    S_BIT_LO: begin
                        if (tick) begin
                            scl_oe <= 1'b0;
                            state  <= S_BIT_HI;
                        end
                    end
                    S_BIT_HI: begin
                        if (tick && i_scl) begin
                            if (!sda_oe && !i_sda) begin
                                // Another master pulled the line: yield.
                                sda_oe         <= 1'b0;
                                flag           <= 1'b1;
                                bus_status_reg <= CODE_ARB_LOST;
                                owned          <= 1'b0;
                                mode           <= mode_none;
                                state          <= S_IDLE;
                            end else begin
                                scl_oe <= 1'b1;
                                if (bitn == 3'(BYTE_BITS - 1)) begin
                                    sda_oe <= 1'b0;
                                    state  <= S_ACK_LO;
                                end else begin
                                    bitn   <= bitn + 1'b1;
                                    shreg  <= {shreg[DATA_W-2:0], 1'b0};
                                    sda_oe <= !shreg[DATA_W-2];
                                    state  <= S_BIT_LO;
                                end
                            end
                        end
                    end
                    S_ACK_LO: begin
                        if (tick) begin
                            scl_oe <= 1'b0;
                            state  <= S_ACK_HI;
                        end
                    end
                    S_ACK_HI: begin
                        if (tick && i_scl) begin
                            scl_oe <= 1'b1;
                            flag   <= 1'b1;
                            state  <= S_HOLD;
                            if (is_addr) begin
                                is_addr <= 1'b0;
                                if (addr_dir) begin
                                    mode <= master_receive_mode;
                                    bus_status_reg <= i_sda ? CODE_SAR_NACK
                                                            : CODE_SAR_ACK;
                                end else begin
                                    mode <= master_transmit_mode;
                                    bus_status_reg <= i_sda ? CODE_SAW_NACK
                                                            : CODE_SAW_ACK;
                                end
                            end else begin
                                bus_status_reg <= i_sda ? CODE_DATA_NACKED
                                                        : CODE_DATA_ACKED;
                            end
                        end
                    end
                    S_STOP_A: begin
                        sda_oe <= 1'b1;
                        if (tick) begin
                            scl_oe <= 1'b0;
                            state  <= S_STOP_B;
                        end
                    end
                    S_STOP_B: begin
                        if (tick && i_scl) begin
                            sda_oe <= 1'b0;
                            state  <= S_STOP_C;
                        end
                    end
                    S_STOP_C: begin
                        // A STOP raises no flag; a queued START follows.
                        if (tick) begin
                            owned     <= 1'b0;
                            mode      <= mode_none;
                            stop_pend <= 1'b0;
                            state     <= start_pend ? S_START_A : S_IDLE;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
    // Low three bits of the code are prescaler bits and read as zero.
    assign o_status              = bus_status_reg & STATUS_MASK;
    assign o_flag                = flag;
    assign o_write_collision_bit = write_collision_bit;
    assign o_stop_pending        = stop_pend;
    assign o_mode                = mode;
    assign o_scl_out             = 1'b0;
    assign o_sda_out             = 1'b0;
    assign o_scl_oe              = scl_oe;
    assign o_sda_oe              = sda_oe;
endmodule

// file: tws_master_tx_properties.sv
// Purpose: Port-level checks for the two-wire master transmit sequencer.
// Assumes: One clock; synchronous active-high reset; short half bit.
// Notes:   Bound below to every instance of the top module.
`timescale 1ns/1ps
module tws_master_tx_properties
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    // Writes
    input wire logic       i_ctl_wr,
    input wire logic       i_ctl_flag_clr,
    input wire logic       i_ctl_start,
    input wire logic       i_ctl_stop,
    input wire logic       i_ctl_enable,
    input wire logic       i_data_wr,
    // Status and pins
    input wire logic [7:0] o_status,
    input wire logic       o_flag,
    input wire logic       o_write_collision_bit,
    input wire logic       o_stop_pending,
    input wire logic [2:0] o_mode,
    input wire logic       o_scl_oe,
    input wire logic       o_sda_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_go;
        i_ce && i_ctl_wr && i_ctl_flag_clr && i_ctl_enable && o_flag;
    endsequence
    sequence s_start_req;
        i_ce && i_ctl_wr && i_ctl_flag_clr && i_ctl_enable && i_ctl_start
            && !i_ctl_stop && !o_flag && o_mode == 3'h0;
    endsequence

    property p_go_clears;
        s_go |=> !o_flag && o_status == CODE_NO_INFO;
    endproperty
    a_go_clears: assert property (p_go_clears)
        else $error("continue left flag set");
    property p_hold;
        o_flag && !i_ctl_wr |=> o_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without write");
    property p_code;
        o_flag |-> o_status inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
                                    8'h30, 8'h38, 8'h40, 8'h48};
    endproperty
    a_code: assert property (p_code)
        else $error("flag with bad status code");
    property p_collide;
        i_ce && i_data_wr && !o_flag |=> o_write_collision_bit;
    endproperty
    a_collide: assert property (p_collide)
        else $error("collision bit not set");
    property p_no_collide;
        i_ce && i_data_wr && o_flag |=> !o_write_collision_bit;
    endproperty
    a_no_collide: assert property (p_no_collide)
        else $error("collision bit not cleared");
    property p_flag_scl;
        $rose(o_flag) && o_status != CODE_ARB_LOST |-> o_scl_oe;
    endproperty
    a_flag_scl: assert property (p_flag_scl)
        else $error("clock line not held at flag");
    property p_mode_dir;
        $rose(o_flag) && o_status[7:4] != 4'h4 && o_status[7:4] != 4'h0
            && o_status != CODE_ARB_LOST && o_status != CODE_REP_START
            |-> o_mode == 3'h1;
    endproperty
    a_mode_dir: assert property (p_mode_dir)
        else $error("write address did not select transmit");
    property p_stop_req;
        s_go ##0 i_ctl_stop && o_status != CODE_ARB_LOST |=> o_stop_pending;
    endproperty
    a_stop_req: assert property (p_stop_req)
        else $error("stop request not pending");
    property p_stop_done;
        $fell(o_stop_pending) |-> o_mode == 3'h0 && !o_scl_oe && !o_sda_oe;
    endproperty
    a_stop_done: assert property (p_stop_done)
        else $error("bus not released after stop");
    property p_start_code;
        s_start_req |-> ##[2:1000] ($rose(o_flag) && o_status == CODE_START);
    endproperty
    a_start_code: assert property (p_start_code)
        else $error("start did not report its code");
endmodule

bind tws_master_tx tws_master_tx_properties u_props (.*);

// file: tws_slave_model.sv
// Purpose: Behavioural slave receiver on the open-drain two-wire bus.
// Assumes: Lines are sampled on the system clock; released lines read high.
// Notes:   Stretching the clock low models a slow slave.
`timescale 1ns/1ps
module tws_slave_model (
    // Clock and controls
    input  wire logic i_mclk,
    input  wire logic i_nack,
    input  wire logic i_slow,
    // Bus lines
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_oe,
    output logic      o_sda_oe,
    // Observed traffic
    output logic [7:0] o_byte,
    output int         o_nstops
);
    logic       scl_q  = 1'b1;
    logic       sda_q  = 1'b1;
    logic       busy   = 1'b0;
    logic       in_ack = 1'b0;
    logic [3:0] bits   = 4'h0;
    logic [7:0] shreg  = 8'h00;
    int         hold   = 0;
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
        o_byte   = 8'h00;
        o_nstops = 0;
    end
    always @(posedge i_mclk) begin
        scl_q <= i_scl;
        sda_q <= i_sda;
        if (i_scl && scl_q && sda_q && !i_sda) begin
            busy   <= 1'b1;
            bits   <= 4'h0;
            in_ack <= 1'b0;
        end
        if (i_scl && scl_q && !sda_q && i_sda) begin
            busy     <= 1'b0;
            o_nstops <= o_nstops + 1;
        end
        if (busy && i_scl && !scl_q && !in_ack && bits < 4'h8) begin
            shreg <= {shreg[6:0], i_sda};
            bits  <= bits + 4'h1;
        end
        if (busy && !i_scl && scl_q) begin
            if (i_slow)
                hold <= 6;
            if (bits == 4'h8 && !in_ack) begin
                in_ack   <= 1'b1;
                o_sda_oe <= !i_nack;
                o_byte   <= shreg;
            end else if (in_ack) begin
                in_ack   <= 1'b0;
                o_sda_oe <= 1'b0;
                bits     <= 4'h0;
            end
        end
        o_scl_oe <= hold > 0;
        if (hold > 0)
            hold <= hold - 1;
    end
endmodule

// file: tws_master_tx_tb.sv
// Purpose: Self-checking bench for the master transmit sequencer.
// Assumes: Half bit shortened to 4 cycles; bus has pull-ups.
// Notes:   Scenarios run in order on one bus with one slave.
`timescale 1ns/1ps
module tws_master_tx_tb;
    import tws_pkg::*;
    logic       i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic       i_ctl_wr = 1'b0, i_ctl_flag_clr = 1'b0, i_ctl_start = 1'b0;
    logic       i_ctl_stop = 1'b0, i_ctl_enable = 1'b1, i_data_wr = 1'b0;
    logic [7:0] i_data = 8'h00, o_status, sm_byte;
    logic [2:0] o_mode;
    logic       nack = 1'b0, slow = 1'b0, scl, sda, sm_scl_oe, sm_sda_oe;
    logic       o_data_ready, o_flag, o_write_collision_bit, o_stop_pending;
    logic       o_scl_oe, o_sda_oe;
    int         n_fail = 0, n_tests = 0, sm_nstops;
    assign scl = !(o_scl_oe || sm_scl_oe);
    assign sda = !(o_sda_oe || sm_sda_oe);

    tws_master_tx #(.HALF_CYC(4), .DEPTH(32)) dut (
        .i_scl(scl), .i_sda(sda), .o_scl_out(), .o_sda_out(), .*);
    tws_slave_model u_slave (.i_mclk(i_mclk), .i_nack(nack), .i_slow(slow),
        .i_scl(scl), .i_sda(sda), .o_scl_oe(sm_scl_oe),
        .o_sda_oe(sm_sda_oe), .o_byte(sm_byte), .o_nstops(sm_nstops));

    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic test_done();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic ctl(input logic st, input logic sp);
        @(posedge i_mclk);
        #1;
        {i_ctl_wr, i_ctl_flag_clr, i_ctl_start, i_ctl_stop} = {2'b11, st, sp};
        @(posedge i_mclk);
        #1;
        i_ctl_wr = 1'b0;
    endtask
    task automatic push(input logic [7:0] b);
        @(posedge i_mclk);
        #1;
        i_data_wr = 1'b1;
        i_data = b;
        @(posedge i_mclk);
        #1;
        i_data_wr = 1'b0;
    endtask
    task automatic wait_flag(input logic [7:0] code);
        int k;
        for (k = 0; k < 3000 && o_flag !== 1'b1; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 3000) begin
            n_fail++;
            test_done();
        end
        check(o_status, code);
    endtask
    task automatic wait_stop(input int stops);
        int k;
        for (k = 0; k < 3000 && o_stop_pending !== 1'b0; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 3000) begin
            n_fail++;
            test_done();
        end
        check(8'(sm_nstops), 8'(stops));
        check({5'h0, o_mode}, 8'h00);
    endtask

    task automatic t_fill_drain();
        push(8'h55);
        check({7'h0, o_write_collision_bit}, 8'h01);
        ctl(1'b1, 1'b0);
        wait_flag(CODE_START);
        push(8'ha4);
        check({7'h0, o_write_collision_bit}, 8'h00);
        for (int k = 0; k < 31; k++)
            push(8'h10 + 8'(k));
        check({7'h0, o_data_ready}, 8'h00);
        push(8'hee);
        slow = 1'b1;
        ctl(1'b0, 1'b0);
        wait_flag(CODE_SAW_ACK);
        check(sm_byte, 8'ha4);
        check({5'h0, o_mode}, 8'h01);
        for (int k = 0; k < 31; k++) begin
            ctl(1'b0, 1'b0);
            wait_flag(CODE_DATA_ACKED);
            check(sm_byte, 8'h10 + 8'(k));
        end
        check({7'h0, o_data_ready}, 8'h01);
        ctl(1'b0, 1'b1);
        wait_stop(1);
        slow = 1'b0;
    endtask
    task automatic t_nack();
        nack = 1'b1;
        ctl(1'b1, 1'b0);
        wait_flag(CODE_START);
        push(8'ha4);
        ctl(1'b0, 1'b0);
        wait_flag(CODE_SAW_NACK);
        push(8'h3c);
        ctl(1'b0, 1'b0);
        wait_flag(CODE_DATA_NACKED);
        check(sm_byte, 8'h3c);
        ctl(1'b0, 1'b1);
        wait_stop(2);
        nack = 1'b0;
    endtask
    task automatic t_read();
        ctl(1'b1, 1'b0);
        wait_flag(CODE_START);
        push(8'ha5);
        ctl(1'b0, 1'b0);
        wait_flag(CODE_SAR_ACK);
        check({5'h0, o_mode}, 8'h02);
        check({7'h0, sm_byte[0]}, 8'h01);
        ctl(1'b0, 1'b1);
        wait_stop(3);
    endtask
    task automatic t_rep();
        ctl(1'b1, 1'b0);
        wait_flag(CODE_START);
        push(8'ha4);
        ctl(1'b0, 1'b0);
        wait_flag(CODE_SAW_ACK);
        ctl(1'b1, 1'b0);
        wait_flag(CODE_REP_START);
        i_ce = 1'b0;
        ctl(1'b0, 1'b0);
        check({7'h0, o_flag}, 8'h01);
        i_ce = 1'b1;
        @(posedge i_mclk);
        #1;
        {i_ctl_wr, i_ctl_enable} = 2'b10;
        @(posedge i_mclk);
        #1;
        {i_ctl_wr, i_ctl_enable} = 2'b01;
        check(o_status, CODE_NO_INFO);
        check({2'h0, o_flag, o_scl_oe, o_sda_oe, o_mode}, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        check(o_status, CODE_NO_INFO);
        check({7'h0, o_flag}, 8'h00);
        check({7'h0, o_data_ready}, 8'h01);
        t_fill_drain();
        t_nack();
        t_read();
        t_rep();
        test_done();
    end
endmodule
